// ### verilog/dmf_top.v
// ds2 multiplexer/demultiplexer and framer channel, top level
`timescale 1ns/1ps
`include "dmf_regs.vh"
module dmf_top #(
	parameter PW = 16,                         // parity counter width
	parameter SW = 8                           // alarm setting width
) (
	input  wire          CLK,                  // 250 mhz clock
	input  wire          RST,                  // async reset, high
	input  wire          FMT_INTL,             // 1 = international
	input  wire          TX_DS2_REQ,           // next ds2 bit wanted
	output wire          TX_DS2_DATA,          // ds2 bit out
	output wire          TX_DS2_VALID,         // ds2 bit strobe
	input  wire [3:0]    TX_TRIB_DATA,         // tributary bits in
	input  wire [3:0]    TX_TRIB_LOW,          // tributary short
	output wire [3:0]    TX_TRIB_RD,           // tributary bit taken
	input  wire          TX_AIS_EN,            // send all ones
	input  wire          TX_X_BIT,             // free overhead bit
	input  wire          TX_LOOP_EN,           // send loop code
	input  wire [3:0]    TX_LOOP_CODE,         // requested loops
	input  wire          TX_RAI,               // remote alarm out
	input  wire          TX_RES_BIT,           // reserved bit out
	input  wire          RX_DS2_DATA,          // ds2 bit in
	input  wire          RX_DS2_VALID,         // ds2 bit strobe
	output reg  [3:0]    RX_TRIB_DATA,         // tributary bits out
	output reg  [3:0]    RX_TRIB_VALID,        // tributary strobes
	output reg           RX_IN_FRAME,          // framer aligned
	output reg  [3:0]    RX_LOOP_REQ,          // loop request flags
	output wire          RX_AIS,               // alarm indication
	output reg           RX_RAI,               // remote alarm in
	input  wire          RX_PAR_EN,            // parity check on
	input  wire          RX_PAR_CLR,           // clear error count
	output reg  [PW-1:0] RX_PAR_ERR_CNT,       // parity errors
	input  wire [SW-1:0] AIS_PERSIST_INTERVAL_SETTING // persistence
);
	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function maj3;
		input [2:0] v;
		maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	function [2:0] pop5;
		input [4:0] v;
		pop5 = {2'd0, v[0]} + {2'd0, v[1]} + {2'd0, v[2]} +
			{2'd0, v[3]} + {2'd0, v[4]};
	endfunction

	// ----------------------------------------------------------------
	// transmit path
	// ----------------------------------------------------------------
	dmf_tx u_tx (
		.clk       (CLK),
		.rst       (RST),
		.intl      (FMT_INTL),
		.ais_en    (TX_AIS_EN),
		.x_bit     (TX_X_BIT),
		.loop_en   (TX_LOOP_EN),
		.loop_code (TX_LOOP_CODE),
		.rai       (TX_RAI),
		.res_bit   (TX_RES_BIT),
		.req       (TX_DS2_REQ),
		.trib_data (TX_TRIB_DATA),
		.trib_low  (TX_TRIB_LOW),
		.ds2_data  (TX_DS2_DATA),
		.ds2_valid (TX_DS2_VALID),
		.trib_rd   (TX_TRIB_RD)
	);

	// ----------------------------------------------------------------
	// receive position and decode
	// ----------------------------------------------------------------
	wire       intl = FMT_INTL;
	wire       d    = RX_DS2_DATA;
	wire [8:0] fas_i = `DMF_I_FAS;
	wire [2:0] mfas  = `DMF_MFAS;
	wire [1:0] fas_a = `DMF_FAS_A;
	reg  [2:0] s_q, b_q;
	reg  [7:0] c_q;
	reg  [1:0] rr_q;
	reg  [8:0] sh_q, jc_q;
	reg  [3:0] good_q;
	reg  [2:0] bad_q, cb_q, lcnt_q;
	reg  [4:0] fh_q;
	reg  [3:0] mh_q, lpc_q, lpp_q;
	reg        acc_q, prv_q;
	reg  [1:0] rcnt_q;
	reg        chk_f, chk_m, okb, info, opp, drop, dbit;
	reg  [1:0] t;
	reg  [7:0] cm1;
	reg  [3:0] oh;
	wire [8:0] sh_n = {sh_q[7:0], d};
	wire [4:0] fh_n = {fh_q[3:0], ~okb};
	wire [3:0] mh_n = {mh_q[2:0], ~okb};
	wire lbit = intl ? (c_q == `DMF_I_LAST_BIT) : (c_q == `DMF_A_LAST_BIT);
	wire lblk = intl | (b_q == `DMF_A_LAST_BLK);
	wire lsub = intl ? (s_q == `DMF_I_LAST_SET) : (s_q == `DMF_A_LAST_SUB);
	wire wrap = lbit & lblk & lsub;
	wire in_fas = intl && s_q == 3'd0 && c_q < `DMF_I_FAS_LEN;
	wire chk_i  = intl && s_q == 3'd0 && c_q == `DMF_I_FAS_END;
	wire fas_ok = sh_n == fas_i;
	wire lof_f  = pop5({1'b0, fh_n[3:0]}) >= 3'd2 || pop5(fh_n) >= 3'd3;
	wire lof_m  = pop5({1'b0, mh_n}) >= 3'd3;
	wire [3:0] good_n = good_q + 4'd1;
	wire [2:0] bad_n  = bad_q + 3'd1;
	wire [2:0] lcnt_n = (lpc_q == lpp_q && lpc_q != 4'h0) ?
		((lcnt_q == `DMF_LOOP_MF) ? lcnt_q : lcnt_q + 3'd1) :
		{2'd0, lpc_q != 4'h0};
	wire ihunt = intl && !RX_IN_FRAME && good_q == 4'd0;

	always @* begin
		cm1   = c_q - 8'd1;
		chk_f = !intl && c_q == 8'd0 &&
			(b_q == `DMF_BLK_F0 || b_q == `DMF_BLK_F1);
		chk_m = !intl && c_q == 8'd0 && b_q == `DMF_BLK_M &&
			s_q != `DMF_A_LAST_SUB;
		okb   = chk_f ? d == fas_a[b_q == `DMF_BLK_F0] :
			d == mfas[2'd2 - s_q[1:0]];
		info  = 1'b0;
		opp   = 1'b0;
		drop  = 1'b0;
		t     = 2'd0;
		dbit  = d;
		if (intl) begin
			opp = s_q == `DMF_I_LAST_SET && c_q >= `DMF_I_OH_LEN &&
				c_q < `DMF_I_OPP_END;
			info = !in_fas && !(s_q != 3'd0 && c_q < `DMF_I_OH_LEN);
			t = opp ? c_q[1:0] - 2'd3 : rr_q;
			drop = opp && maj3({jc_q[3'd2 - t], jc_q[3'd5 - t],
				jc_q[4'd8 - t]});
		end else begin
			info = c_q != 8'd0;
			t    = cm1[1:0];
			drop = b_q == `DMF_A_LAST_BLK && cm1 == {5'd0, s_q} &&
				maj3(cb_q);
			dbit = d ^ t[0];
		end
		oh = 4'h0;
		oh[t] = info & ~drop;
	end

	// ----------------------------------------------------------------
	// framer, demultiplexer and overhead monitors
	// ----------------------------------------------------------------
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_q <= 3'd0; b_q <= 3'd0; c_q <= 8'd0; rr_q <= 2'd0;
			sh_q <= 9'd0; jc_q <= 9'd0; good_q <= 4'd0; bad_q <= 3'd0;
			fh_q <= 5'd0; mh_q <= 4'd0; cb_q <= 3'd0; lcnt_q <= 3'd0;
			lpc_q <= 4'h0; lpp_q <= 4'h0; acc_q <= 1'b0; prv_q <= 1'b0;
			rcnt_q <= 2'd0; RX_TRIB_DATA <= 4'h0; RX_TRIB_VALID <= 4'h0;
			RX_IN_FRAME <= 1'b0; RX_LOOP_REQ <= 4'h0; RX_RAI <= 1'b0;
			RX_PAR_ERR_CNT <= {PW{1'b0}};
		end else begin
			RX_TRIB_VALID <= 4'h0;
			// a new error wins over a clear in the same cycle
			if (RX_PAR_CLR)
				RX_PAR_ERR_CNT <= {PW{1'b0}};
			if (!RX_IN_FRAME) begin
				lcnt_q      <= 3'd0;
				RX_LOOP_REQ <= 4'h0;
			end
			if (RX_DS2_VALID) begin
				sh_q <= sh_n;
				// position: hunt jumps on the word, ansi hunt slips
				if (ihunt) begin
					if (fas_ok) begin
						s_q    <= 3'd0;
						c_q    <= `DMF_I_FAS_LEN;
						good_q <= 4'd1;
					end
				end else if (!RX_IN_FRAME && (chk_f | chk_m) && !okb) begin
					good_q <= 4'd0;
				end else if (lbit) begin
					c_q <= 8'd0;
					if (lblk) begin
						b_q <= 3'd0;
						s_q <= lsub ? 3'd0 : s_q + 3'd1;
					end else
						b_q <= b_q + 3'd1;
				end else
					c_q <= c_q + 8'd1;
				// ansi alignment and loss
				if ((chk_f | chk_m) && !RX_IN_FRAME && okb) begin
					good_q <= good_n;
					if (good_n == `DMF_A_SYNC_N) begin
						RX_IN_FRAME <= 1'b1;
						fh_q <= 5'd0;
						mh_q <= 4'd0;
					end
				end
				if ((chk_f | chk_m) && RX_IN_FRAME) begin
					if (chk_f)
						fh_q <= fh_n;
					else
						mh_q <= mh_n;
					if ((chk_f && lof_f) || (chk_m && lof_m)) begin
						RX_IN_FRAME <= 1'b0;
						good_q <= 4'd0;
					end
				end
				// international alignment and loss
				if (chk_i && !RX_IN_FRAME && good_q != 4'd0) begin
					good_q <= fas_ok ? good_n : 4'd0;
					if (fas_ok && good_n == `DMF_I_SYNC_N) begin
						RX_IN_FRAME <= 1'b1;
						bad_q <= 3'd0;
					end
				end
				if (chk_i && RX_IN_FRAME) begin
					bad_q <= fas_ok ? 3'd0 : bad_n;
					if (!fas_ok && bad_n == `DMF_I_LOF_N) begin
						RX_IN_FRAME <= 1'b0;
						good_q <= 4'd0;
					end
				end
				// control bit capture
				if (!intl && c_q == 8'd0 && (b_q == `DMF_BLK_C1 ||
					b_q == `DMF_BLK_C2 || b_q == `DMF_BLK_C3))
					cb_q <= {cb_q[1:0], d};
				if (intl && s_q >= `DMF_I_SET_JC && c_q < `DMF_I_OH_LEN)
					jc_q <= {jc_q[7:0], d};
				if (in_fas)
					rr_q <= 2'd0;
				else if (intl && info && !opp)
					rr_q <= (rr_q == 2'd2) ? 2'd0 : rr_q + 2'd1;
				if (RX_IN_FRAME) begin
					// tributary output
					RX_TRIB_VALID <= oh;
					RX_TRIB_DATA  <= (RX_TRIB_DATA & ~oh) | ({4{dbit}} & oh);
					// loopback request: third control bit inverted
					if (!intl && c_q == 8'd0 && b_q == `DMF_BLK_C3)
						lpc_q[s_q[1:0]] <= cb_q[0] == cb_q[1] && d != cb_q[0];
					if (!intl && wrap) begin
						lpp_q  <= lpc_q;
						lcnt_q <= lcnt_n;
						RX_LOOP_REQ <= (lcnt_n == `DMF_LOOP_MF) ?
							lpc_q : 4'h0;
					end
					// parity over tributary bits of the previous frame
					if (intl && wrap) begin
						prv_q <= acc_q ^ d;
						acc_q <= 1'b0;
					end else if (intl && info)
						acc_q <= acc_q ^ d;
					if (intl && RX_PAR_EN && s_q == `DMF_I_SET_RAI &&
						c_q == `DMF_I_BIT_PAR && d != prv_q &&
						RX_PAR_ERR_CNT != {PW{1'b1}})
						RX_PAR_ERR_CNT <= (RX_PAR_CLR ? {PW{1'b0}} :
							RX_PAR_ERR_CNT) + {{(PW-1){1'b0}}, 1'b1};
					// remote alarm change must hold three frames
					if (intl && s_q == `DMF_I_SET_RAI && c_q == 8'd0) begin
						if (d == RX_RAI)
							rcnt_q <= 2'd0;
						else if (rcnt_q == `DMF_RAI_MF - 2'd1) begin
							RX_RAI <= d;
							rcnt_q <= 2'd0;
						end else
							rcnt_q <= rcnt_q + 2'd1;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// alarm indication detector
	// ----------------------------------------------------------------
	dmf_ais #(
		.SW (SW)
	) u_ais (
		.clk      (CLK),
		.rst      (RST),
		.intl     (intl),
		.bit_vld  (RX_DS2_VALID),
		.bit_val  (d),
		.in_frame (RX_IN_FRAME),
		.setting  (AIS_PERSIST_INTERVAL_SETTING),
		.ais      (RX_AIS)
	);
endmodule // dmf_top

// ### verilog/dmf_regs.vh
// constants for the ds2 multiplexer and framer channel
`ifndef DMF_REGS_VH
`define DMF_REGS_VH
// ----------------------------------------------------------------
// ansi-style multiframe: 4 subframes x 6 blocks x 49 bits
// ----------------------------------------------------------------
`define DMF_A_LAST_BIT 8'd48
`define DMF_A_LAST_BLK 3'd5
`define DMF_A_LAST_SUB 3'd3
`define DMF_MFAS       3'b011
`define DMF_FAS_A      2'b01
`define DMF_BLK_M      3'd0
`define DMF_BLK_C1     3'd1
`define DMF_BLK_F0     3'd2
`define DMF_BLK_C2     3'd3
`define DMF_BLK_C3     3'd4
`define DMF_BLK_F1     3'd5
`define DMF_A_SYNC_N   4'd11
`define DMF_A_MF_BITS  11'd1176
// ----------------------------------------------------------------
// international frame: 5 sets x 168 bits
// ----------------------------------------------------------------
`define DMF_I_LAST_BIT 8'd167
`define DMF_I_LAST_SET 3'd4
`define DMF_I_FAS      9'b111010000
`define DMF_I_FAS_LEN  8'd9
`define DMF_I_FAS_END  8'd8
`define DMF_I_OH_LEN   8'd3
`define DMF_I_OPP_END  8'd6
`define DMF_I_SET_RAI  3'd1
`define DMF_I_SET_JC   3'd2
`define DMF_I_BIT_PAR  8'd1
`define DMF_I_SYNC_N   4'd3
`define DMF_I_LOF_N    3'd4
`define DMF_I_MF_BITS  11'd840
// ----------------------------------------------------------------
// alarm and loopback figures
// ----------------------------------------------------------------
`define DMF_AIS_WIN_A  12'd3156
`define DMF_AIS_WIN_I  12'd1680
`define DMF_AIS_ZLIM_A 3'd3
`define DMF_AIS_ZLIM_I 3'd5
`define DMF_LOOP_MF    3'd5
`define DMF_RAI_MF     2'd3
`endif

// ### verilog/dmf_tx.v
// transmit frame builder and tributary multiplexer
`timescale 1ns/1ps
`include "dmf_regs.vh"
module dmf_tx (
	input  wire       clk,        // system clock
	input  wire       rst,        // async reset, high
	input  wire       intl,       // international format
	input  wire       ais_en,     // send all ones
	input  wire       x_bit,      // subframe 4 block 1 bit
	input  wire       loop_en,    // send loopback code
	input  wire [3:0] loop_code,  // tributaries to request
	input  wire       rai,        // remote alarm bit
	input  wire       res_bit,    // reserved bit value
	input  wire       req,        // next bit wanted
	input  wire [3:0] trib_data,  // current tributary bits
	input  wire [3:0] trib_low,   // tributary short of data
	output reg        ds2_data,   // outgoing bit
	output reg        ds2_valid,  // bit strobe
	output reg  [3:0] trib_rd     // tributary bit taken
);
	wire [8:0] fas_i  = `DMF_I_FAS;
	wire [2:0] mfas   = `DMF_MFAS;
	wire [1:0] fas_a  = `DMF_FAS_A;
	reg  [2:0] s_q, b_q;
	reg  [7:0] c_q;
	reg  [1:0] rr_q;
	reg        stf_q, acc_q, par_q;
	reg  [2:0] jst_q;
	reg        bitv, tb, opp;
	reg  [3:0] rd;
	reg  [1:0] t;
	reg  [7:0] cm1;
	wire lbit = intl ? (c_q == `DMF_I_LAST_BIT) : (c_q == `DMF_A_LAST_BIT);
	wire lblk = intl | (b_q == `DMF_A_LAST_BLK);
	wire lsub = intl ? (s_q == `DMF_I_LAST_SET) : (s_q == `DMF_A_LAST_SUB);
	wire in_fas = intl && s_q == 3'd0 && c_q < `DMF_I_FAS_LEN;

	// ----------------------------------------------------------------
	// bit selection
	// ----------------------------------------------------------------
	always @* begin
		bitv = 1'b0;
		rd   = 4'h0;
		tb   = 1'b0;
		opp  = 1'b0;
		t    = 2'd0;
		cm1  = c_q - 8'd1;
		if (intl) begin
			if (in_fas)
				bitv = fas_i[4'd8 - c_q[3:0]];
			else if (s_q == `DMF_I_SET_RAI && c_q < `DMF_I_OH_LEN) begin
				case (c_q[1:0])
				2'd0:    bitv = rai;
				2'd1:    bitv = par_q;
				default: bitv = res_bit;
				endcase
			end else if (s_q >= `DMF_I_SET_JC && c_q < `DMF_I_OH_LEN)
				bitv = jst_q[c_q[1:0]];
			else if (s_q == `DMF_I_LAST_SET && c_q < `DMF_I_OPP_END) begin
				opp = 1'b1;
				tb  = 1'b1;
				t   = c_q[1:0] - 2'd3;
				if (!jst_q[t]) begin
					rd[t] = 1'b1;
					bitv  = trib_data[t];
				end
			end else begin
				tb    = 1'b1;
				t     = rr_q;
				rd[t] = 1'b1;
				bitv  = trib_data[t];
			end
		end else if (c_q == 8'd0) begin
			case (b_q)
			`DMF_BLK_M: bitv = (s_q == `DMF_A_LAST_SUB) ? x_bit :
				mfas[2'd2 - s_q[1:0]];
			`DMF_BLK_F0: bitv = fas_a[1];
			`DMF_BLK_F1: bitv = fas_a[0];
			// inverted third bit keeps the 2 of 3 vote intact
			`DMF_BLK_C3: bitv = stf_q ^ (loop_en & loop_code[s_q[1:0]]);
			default: bitv = stf_q;
			endcase
		end else begin
			t = cm1[1:0];
			if (b_q == `DMF_A_LAST_BLK && cm1 == {5'd0, s_q} && stf_q)
				bitv = 1'b0;
			else begin
				rd[t] = 1'b1;
				bitv  = trib_data[t] ^ t[0];
			end
		end
		if (ais_en) begin
			bitv = 1'b1;
			rd   = 4'h0;
		end
	end

	// ----------------------------------------------------------------
	// counters and outputs
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= 3'd0; b_q <= 3'd0; c_q <= 8'd0; rr_q <= 2'd0;
			stf_q <= 1'b0; jst_q <= 3'd0; acc_q <= 1'b0; par_q <= 1'b0;
			ds2_data <= 1'b0; ds2_valid <= 1'b0; trib_rd <= 4'h0;
		end else begin
			ds2_valid <= req;
			trib_rd   <= req ? rd : 4'h0;
			if (req) begin
				ds2_data <= bitv;
				if (!intl && c_q == 8'd0 && b_q == `DMF_BLK_M)
					stf_q <= trib_low[s_q[1:0]];
				if (in_fas)
					rr_q <= 2'd0;
				else if (tb && !opp)
					rr_q <= (rr_q == 2'd2) ? 2'd0 : rr_q + 2'd1;
				if (intl && s_q == 3'd0 && c_q == 8'd0)
					jst_q <= trib_low[2:0];
				if (lbit && lblk && lsub) begin
					par_q <= acc_q ^ (tb & bitv);
					acc_q <= 1'b0;
				end else if (tb)
					acc_q <= acc_q ^ bitv;
				if (lbit) begin
					c_q <= 8'd0;
					if (lblk) begin
						b_q <= 3'd0;
						s_q <= lsub ? 3'd0 : s_q + 3'd1;
					end else
						b_q <= b_q + 3'd1;
				end else
					c_q <= c_q + 8'd1;
			end
		end
	end
endmodule // dmf_tx

// ### verilog/dmf_ais.v
// alarm indication detector for the received ds2 stream
`timescale 1ns/1ps
`include "dmf_regs.vh"
module dmf_ais #(
	parameter SW = 8                // width of the interval setting
) (
	input  wire          clk,       // system clock
	input  wire          rst,       // async reset, high
	input  wire          intl,      // international format
	input  wire          bit_vld,   // received bit strobe
	input  wire          bit_val,   // received bit
	input  wire          in_frame,  // framer aligned
	input  wire [SW-1:0] setting,   // multiframes to persist
	output reg           ais        // alarm indication
);
	reg  [11:0]   win_q;
	reg  [10:0]   mf_q;
	reg  [2:0]    z_q;
	reg           cond_q;
	reg  [SW-1:0] per_q;
	wire [11:0] wlast = intl ? `DMF_AIS_WIN_I - 12'd1 : `DMF_AIS_WIN_A - 12'd1;
	wire [10:0] mlast = intl ? `DMF_I_MF_BITS - 11'd1 : `DMF_A_MF_BITS - 11'd1;
	wire [2:0]  zlim  = intl ? `DMF_AIS_ZLIM_I : `DMF_AIS_ZLIM_A;
	wire [2:0]  z_n   = (!bit_val && z_q != 3'd7) ? z_q + 3'd1 : z_q;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			win_q <= 12'd0; mf_q <= 11'd0; z_q <= 3'd0;
			cond_q <= 1'b0; per_q <= {SW{1'b0}}; ais <= 1'b0;
		end else if (in_frame) begin
			cond_q <= 1'b0;
			per_q  <= {SW{1'b0}};
			ais    <= 1'b0;
		end else if (bit_vld) begin
			if (win_q == wlast) begin
				win_q  <= 12'd0;
				z_q    <= 3'd0;
				cond_q <= z_n < zlim;
			end else begin
				win_q <= win_q + 12'd1;
				z_q   <= z_n;
			end
			mf_q <= (mf_q == mlast) ? 11'd0 : mf_q + 11'd1;
			if (mf_q == mlast) begin
				if (!cond_q) begin
					per_q <= {SW{1'b0}};
					ais   <= 1'b0;
				end else if (per_q >= setting)
					ais <= 1'b1;
				else
					per_q <= per_q + {{(SW-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // dmf_ais

// ### sim/dmf_checker.sv
// assertion checker on the ds2 channel top ports
`timescale 1ns/1ps
module dmf_checker #(
	parameter PW = 16                   // parity counter width
) (
	input wire          CLK,            // clock
	input wire          RST,            // reset
	input wire          FMT_INTL,       // format
	input wire          TX_DS2_REQ,     // bit wanted
	input wire          TX_DS2_DATA,    // bit out
	input wire          TX_DS2_VALID,   // bit strobe
	input wire [3:0]    TX_TRIB_RD,     // trib taken
	input wire          TX_AIS_EN,      // all ones
	input wire          RX_DS2_VALID,   // bit in
	input wire [3:0]    RX_TRIB_VALID,  // trib out
	input wire          RX_IN_FRAME,    // aligned
	input wire          RX_AIS,         // alarm
	input wire          RX_PAR_CLR,     // clear
	input wire [PW-1:0] RX_PAR_ERR_CNT  // errors
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence req_s; TX_DS2_REQ; endsequence
	sequence bit_s; TX_DS2_VALID ##0 $onehot0(TX_TRIB_RD); endsequence
	bit_follows_a: assert property (req_s |=> bit_s)
		else $error("request without a bit one cycle later");
	rd_with_req_a: assert property (|TX_TRIB_RD |-> $past(TX_DS2_REQ))
		else $error("tributary read without a request");
	ais_ones_a: assert property (TX_DS2_VALID && $past(TX_AIS_EN) |->
		TX_DS2_DATA && TX_TRIB_RD == 4'h0)
		else $error("alarm signal bit not one or tributary read");
	intl_three_a: assert property (FMT_INTL && $past(FMT_INTL, 2) |->
		!TX_TRIB_RD[3] && !RX_TRIB_VALID[3])
		else $error("fourth tributary used in three-tributary format");
	out_in_frame_a: assert property (|RX_TRIB_VALID |->
		$past(RX_DS2_VALID) && (RX_IN_FRAME || $past(RX_IN_FRAME)))
		else $error("tributary output while out of frame");
	ais_oof_a: assert property ($rose(RX_AIS) |-> !$past(RX_IN_FRAME))
		else $error("alarm raised while in frame");
	ais_clear_a: assert property (RX_IN_FRAME [*4] |-> !RX_AIS)
		else $error("alarm held while in frame");
	par_clear_a: assert property (RX_PAR_CLR |=> RX_PAR_ERR_CNT <= 1)
		else $error("parity count not cleared");
endmodule // dmf_checker
bind dmf_top dmf_checker #(.PW(PW)) u_chk (
	.CLK(CLK), .RST(RST), .FMT_INTL(FMT_INTL), .TX_DS2_REQ(TX_DS2_REQ),
	.TX_DS2_DATA(TX_DS2_DATA), .TX_DS2_VALID(TX_DS2_VALID),
	.TX_TRIB_RD(TX_TRIB_RD), .TX_AIS_EN(TX_AIS_EN),
	.RX_DS2_VALID(RX_DS2_VALID), .RX_TRIB_VALID(RX_TRIB_VALID),
	.RX_IN_FRAME(RX_IN_FRAME), .RX_AIS(RX_AIS), .RX_PAR_CLR(RX_PAR_CLR),
	.RX_PAR_ERR_CNT(RX_PAR_ERR_CNT)
);

// ### sim/dmf_far_model.sv
// far-side model: requests ds2 bits, records them, loops them back
`timescale 1ns/1ps
module dmf_far_model (
	input  wire clk,      // clock
	input  wire rst,      // reset
	input  wire corrupt,  // invert looped bits
	input  wire tx_data,  // channel bit
	input  wire tx_valid, // channel strobe
	output reg  req,      // bit request
	output reg  rx_data,  // looped bit
	output reg  rx_valid  // looped strobe
);
	reg [10:0] cnt_q;
	reg        bits_q [0:1175];
	// idle line shows the inverse of the last bit, never a stale copy
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			req      <= 1'h0;
			rx_data  <= 1'h0;
			rx_valid <= 1'h0;
			cnt_q    <= 11'h0;
		end else begin
			req      <= ~req;
			rx_valid <= tx_valid;
			rx_data  <= tx_valid ? tx_data ^ corrupt : ~rx_data;
			if (tx_valid && cnt_q != 11'h498) begin
				bits_q[cnt_q] <= tx_data;
				cnt_q         <= cnt_q + 11'h1;
			end
		end
	end
endmodule // dmf_far_model

// ### sim/dmf_top_tb.sv
// self-checking bench for the ds2 channel
`timescale 1ns/1ps
module dmf_top_tb;
	reg         clk = 1'h0, rst = 1'h1, fmt = 1'h0, ais_en = 1'h0;
	reg         x_bit = 1'h1, loop_en = 1'h0, rai = 1'h0, res_bit = 1'h0;
	reg         par_en = 1'h0, par_clr = 1'h0, corrupt = 1'h0;
	reg  [3:0]  tdata = 4'h3, tlow = 4'h1, lcode = 4'h0;
	reg  [7:0]  persist = 8'h02;
	wire        req, txd, txv, rxd, rxv, in_frame, ais, rrai;
	wire [3:0]  trd, rtd, rtv, lreq;
	wire [15:0] perr;
	integer     fails = 0, check_count = 0, n, k, s, b, t;
	dmf_top DUT (.CLK(clk), .RST(rst), .FMT_INTL(fmt), .TX_DS2_REQ(req),
		.TX_DS2_DATA(txd), .TX_DS2_VALID(txv), .TX_TRIB_DATA(tdata),
		.TX_TRIB_LOW(tlow), .TX_TRIB_RD(trd), .TX_AIS_EN(ais_en),
		.TX_X_BIT(x_bit), .TX_LOOP_EN(loop_en), .TX_LOOP_CODE(lcode),
		.TX_RAI(rai), .TX_RES_BIT(res_bit), .RX_DS2_DATA(rxd),
		.RX_DS2_VALID(rxv), .RX_TRIB_DATA(rtd), .RX_TRIB_VALID(rtv),
		.RX_IN_FRAME(in_frame), .RX_LOOP_REQ(lreq), .RX_AIS(ais),
		.RX_RAI(rrai), .RX_PAR_EN(par_en), .RX_PAR_CLR(par_clr),
		.RX_PAR_ERR_CNT(perr), .AIS_PERSIST_INTERVAL_SETTING(persist));
	dmf_far_model FAR (.clk(clk), .rst(rst), .corrupt(corrupt),
		.tx_data(txd), .tx_valid(txv), .req(req), .rx_data(rxd),
		.rx_valid(rxv));
	always #2 clk = ~clk;
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task chk(input [63:0] what, input [15:0] seen, input [15:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
			end
		end
	endtask
	task close_out;
		begin
			$display("checks %0d mismatches %0d", check_count, fails);
			if (fails == 0 && check_count > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task tick;
		begin
			@(posedge clk);
			#1;
		end
	endtask
	task do_reset;
		begin
			rst <= 1'h1;
			repeat (3) @(posedge clk);
			rst <= 1'h0;
		end
	endtask
	// waits for the alarm (sel) or frame flag to reach v, bounded
	task wsig(input sel, input v, input integer lim);
		begin
			n = 0;
			while (((sel ? ais : in_frame) !== v) && n < lim) begin
				tick;
				n = n + 1;
			end
			chk("wait", n < lim, 1'h1);
		end
	endtask
	// watches tributary outputs for cyc cycles against the sent bits
	task watch(input integer cyc);
		begin
			n = 0;
			for (t = 0; t < cyc; t = t + 1) begin
				tick;
				for (k = 0; k < 4; k = k + 1)
					if (rtv[k] === 1'h1) begin
						n = n + 1;
						chk("trib", rtd[k], tdata[k]);
					end
			end
			chk("tribs", n > 0, 1'h1);
		end
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_ansi_tx;
		begin
			@(posedge clk);
			do_reset;
			repeat (2400) @(posedge clk);
			chk("count", FAR.cnt_q, 11'h498);
			for (s = 0; s < 4; s = s + 1)
				for (b = 0; b < 6; b = b + 1) begin
					t = s * 294 + b * 49;
					chk("oh", FAR.bits_q[t], (b == 0) ? (s != 0) :
						(b == 2) ? 1'h0 : (b == 5) ? 1'h1 : (s == 0));
					for (k = 1; k < 49; k = k + 1)
						chk("info", FAR.bits_q[t + k],
							(s == 0 && b == 5 && k == 1) ? 1'h0 :
							tdata[(k - 1) % 4] ^ (k % 2 == 0));
				end
			$display("test ansi_tx done");
		end
	endtask
	task t_ansi_rx;
		begin
			@(posedge clk);
			loop_en <= 1'h1;
			lcode   <= 4'ha;
			wsig(1'h0, 1'h1, 30000);
			chk("loop", lreq, 4'h0);
			watch(16000);
			chk("loop", lreq, 4'ha);
			// bench plays the processor and never closes the loop, so
			// the channel must go on taking tributary bits
			n = 0;
			repeat (8) begin
				tick;
				n = n | trd;
			end
			chk("noloop", n != 0, 1'h1);
			$display("test ansi_rx done");
		end
	endtask
	task t_lof_ais;
		begin
			@(posedge clk);
			corrupt <= 1'h1;
			wsig(1'h0, 1'h0, 1300);
			@(posedge clk);
			corrupt <= 1'h0;
			ais_en  <= 1'h1;
			wsig(1'h1, 1'h1, 20000);
			chk("ais", n >= 4704, 1'h1);
			$display("test lof_ais done");
		end
	endtask
	task t_intl;
		begin
			@(posedge clk);
			fmt    <= 1'h1;
			rai    <= 1'h1;
			res_bit <= 1'h1;
			ais_en <= 1'h0;
			tlow   <= 4'h0;
			par_en <= 1'h1;
			do_reset;
			repeat (1700) @(posedge clk);
			for (k = 0; k < 9; k = k + 1)
				chk("fas", FAR.bits_q[k], k < 3 || k == 4);
			chk("rai", FAR.bits_q[168], 1'h1);
			chk("res", FAR.bits_q[170], 1'h1);
			chk("jc", FAR.bits_q[336], 1'h0);
			wsig(1'h0, 1'h1, 8000);
			chk("sync", n > 1000, 1'h1);
			watch(7000);
			chk("rai", rrai, 1'h1);
			chk("perr", perr, 16'h0);
			par_clr <= 1'h1;
			@(posedge clk);
			par_clr <= 1'h0;
			corrupt <= 1'h1;
			wsig(1'h0, 1'h0, 12000);
			chk("lof time", n > 5040 && n < 6760, 1'h1);
			$display("test intl done");
		end
	endtask
	// ----------------------------------------------------------------
	// sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		t_ansi_tx;
		t_ansi_rx;
		t_lof_ais;
		t_intl;
		close_out;
	end
	initial begin
		// all scenarios at their limits take about 98400 cycles, more than the 80000 below
		repeat (80000) @(posedge clk);
		fails = fails + 1;
		close_out;
	end
endmodule // dmf_top_tb
